/* File: hdl/asr_pkg.sv */
// Purpose : Shared constants for the asynchronous serial receiver
// Assumes : 32-bit APB register bus, 16x oversampling tick
// Notes   : Offsets are byte addresses, one aligned word per register
package asr_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] BAUD_OFS   = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] DATA_OFS   = 8'h0C;

  // ************************************************************
  // Control fields
  // ************************************************************
  localparam int CTRL_SERIAL_PORT_ON    = 0;
  localparam int CTRL_CONTINUOUS_RX_ON  = 1;
  localparam int CTRL_NINE_BIT_RX_SEL   = 2;
  localparam int CTRL_ADDR_DETECT_ON    = 3;
  localparam int CTRL_SYNC_MODE_SEL     = 4;
  localparam int CTRL_RX_IRQ_ENABLE     = 5;
  localparam int CTRL_PERIPH_IRQ_MASTER = 6;
  localparam int CTRL_GLOBAL_IRQ_ENABLE = 7;
  localparam int CTRL_WIDTH             = 8;
  localparam logic [7:0] CTRL_RESET     = 8'h00;

  // ************************************************************
  // Status fields
  // ************************************************************
  localparam int STAT_FRAMING_ERR = 0;
  localparam int STAT_OVERRUN     = 1;
  localparam int STAT_NINTH_BIT   = 2;
  localparam int STAT_RX_PENDING  = 3;
  localparam int STAT_RX_BUSY     = 4;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0001;
  localparam int          OVERSAMPLE     = 16;
  localparam logic [3:0]  MID_TICK       = 4'h9;
  localparam logic [3:0]  DATA_BITS_8    = 4'h8;
  localparam logic [3:0]  DATA_BITS_9    = 4'h9;
  localparam int          FIFO_DEPTH     = 2;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } asr_rx_state_t;

endpackage : asr_pkg

/* File: hdl/asr_receiver.sv */
// Purpose : Asynchronous serial receiver with APB register access
// Assumes : serialRxPin synchronous to clock; 16 ticks per bit
// Notes   : Two-entry FIFO, framing and overrun status, address mode
//
// Function
// - Character starts on falling idle line edge
// - Half bit recheck; abort silently if high
// - Each bit centre, majority vote shifted in
// - Low stop sample flags framing error
// - Completed character enters FIFO, flag set
// - Data read returns and removes oldest character
// - Pending flag equals active and FIFO nonempty
// - Interrupt needs all three enables set
// - Framing flag stored per character, head shown
// - Framing error needs no clear, no interrupt
// - Port off resets receiver; rx-off keeps framing
// - Third character into full FIFO sets overrun
// - Overrun blocks intake; cleared by enable clear
// - Nine-bit mode shifts nine, ninth shown
// - Address mode in nine-bit mode keeps only ninth-bit-set characters
// - Active only when enabled, async, port on
// - Recovery on 16x tick, shift once per bit
// - Least significant bit first
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module asr_receiver
  import asr_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        serialRxPin,
  output logic             rxPendingFlag,
  output logic             rxIrq
);
  import asr_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [CTRL_WIDTH-1:0] ctrl_q;
  logic [DIV_W-1:0]      baudDiv_q;
  logic                  overrun_q;
  logic                  popArm_q;
  logic                  rxPrev_q;
  logic [1:0]            hist_q;
  logic [3:0]            tickCnt_q;
  logic [3:0]            bitCnt_q;
  logic [8:0]            shift_q;
  asr_rx_state_t         state_q;

  logic       serialPortOn;
  logic       continuousRxOn;
  logic       nineBitRxSel;
  logic       addrDetectOn;
  logic       rxActive;
  logic       tick;
  logic       vote;
  logic       atCentre;
  logic       charDone;
  logic       keepChar;
  logic       push;
  logic       pop;
  logic       apbSetup;
  logic       apbDone;
  logic       fifoEmpty;
  logic       fifoFull;
  logic [9:0] headData;
  logic [9:0] newChar;
  logic [7:0] dataBits;
  logic       ninthBit;
  logic       mapped;

  function automatic logic majority3(input logic a, input logic b, input logic c);
    majority3 = (a & b) | (a & c) | (b & c);
  endfunction : majority3

  function automatic logic addrHit(input logic [7:0] a);
    addrHit = (a == CTRL_OFS) || (a == BAUD_OFS) || (a == STATUS_OFS) ||
              (a == DATA_OFS);
  endfunction : addrHit

  assign serialPortOn   = ctrl_q[CTRL_SERIAL_PORT_ON];
  assign continuousRxOn = ctrl_q[CTRL_CONTINUOUS_RX_ON];
  assign nineBitRxSel   = ctrl_q[CTRL_NINE_BIT_RX_SEL];
  assign addrDetectOn   = ctrl_q[CTRL_ADDR_DETECT_ON];
  assign rxActive       = serialPortOn & continuousRxOn & ~ctrl_q[CTRL_SYNC_MODE_SEL];

  // ************************************************************
  // APB slave
  // ************************************************************
  // Access phase lasts two cycles: data is captured, then pready is raised
  assign apbSetup = psel & penable & ~pready;
  assign apbDone  = psel & penable & pready;
  assign mapped   = addrHit(paddr);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apbSetup;
      pslverr <= apbSetup & ~mapped;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (apbSetup && !pwrite)
    begin
      unique case (paddr)
        CTRL_OFS:   prdata <= 32'(ctrl_q);
        BAUD_OFS:   prdata <= 32'(baudDiv_q);
        STATUS_OFS: prdata <= {27'h0, state_q != RX_IDLE, rxPendingFlag,
                               ninthBit, overrun_q, headData[9] & ~fifoEmpty};
        DATA_OFS:   prdata <= {24'h0, headData[7:0] & {8{~fifoEmpty}}};
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Pop only a character that was already visible when the read data was captured
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      popArm_q <= 1'b0;
    end
    else if (apbSetup)
    begin
      popArm_q <= !pwrite && (paddr == DATA_OFS) && !fifoEmpty;
    end
  end

  assign pop = apbDone & popArm_q;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_q <= CTRL_RESET;
    end
    else if (apbDone && pwrite && paddr == CTRL_OFS)
    begin
      ctrl_q <= pwdata[CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      baudDiv_q <= BAUD_DIV_RESET;
    end
    else if (apbDone && pwrite && paddr == BAUD_OFS)
    begin
      baudDiv_q <= pwdata[DIV_W-1:0];
    end
  end

  // ************************************************************
  // Data recovery
  // ************************************************************
  asr_tick_gen #(
    .DIV_W   (DIV_W)
  ) u_tick (
    .clock   (clock),
    .rst     (rst),
    .run     (rxActive),
    .divisor (baudDiv_q),
    .tick    (tick)
  );

  // Vote over samples at ticks 7, 8 and 9 of the bit
  assign vote     = majority3(hist_q[1], hist_q[0], serialRxPin);
  assign atCentre = tick && (tickCnt_q == MID_TICK);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      hist_q   <= 2'b11;
      rxPrev_q <= 1'b1;
    end
    else
    begin
      rxPrev_q <= serialRxPin;
      if (tick)
      begin
        hist_q <= {hist_q[0], serialRxPin};
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst || !rxActive || state_q == RX_IDLE)
    begin
      tickCnt_q <= 4'h0;
    end
    else if (tick)
    begin
      tickCnt_q <= tickCnt_q + 4'h1;
    end
  end

  // Leaving the receive enable off returns the machine to idle
  always_ff @(posedge clock)
  begin
    if (rst || !rxActive)
    begin
      state_q <= RX_IDLE;
    end
    else
    begin
      unique case (state_q)
        RX_IDLE:
        begin
          if (rxPrev_q && !serialRxPin)
          begin
            state_q <= RX_START;
          end
        end
        RX_START:
        begin
          if (atCentre)
          begin
            state_q <= vote ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (atCentre && bitCnt_q == (nineBitRxSel ? DATA_BITS_9 : DATA_BITS_8) - 4'h1)
          begin
            state_q <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          if (atCentre)
          begin
            state_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst || state_q == RX_IDLE)
    begin
      bitCnt_q <= 4'h0;
    end
    else if (state_q == RX_DATA && atCentre)
    begin
      bitCnt_q <= bitCnt_q + 4'h1;
    end
  end

  // Shift right so the first bit received ends at bit 0 in nine-bit mode
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      shift_q <= 9'h000;
    end
    else if (state_q == RX_DATA && atCentre)
    begin
      shift_q <= {vote, shift_q[8:1]};
    end
  end

  // In eight-bit mode the character sits one place high
  assign dataBits = nineBitRxSel ? shift_q[7:0] : shift_q[8:1];
  assign newChar  = {~vote, nineBitRxSel & shift_q[8], dataBits};

  // ************************************************************
  // FIFO and status
  // ************************************************************
  assign charDone = rxActive && state_q == RX_STOP && atCentre;
  assign keepChar = !(addrDetectOn && nineBitRxSel && !shift_q[8]);
  assign push     = charDone && keepChar && !overrun_q && !fifoFull;

  // Storage keeps 8 data bits, the ninth bit and the framing flag
  asr_rx_fifo #(
    .WIDTH    (10),
    .DEPTH    (FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .flush    (rst || !serialPortOn),
    .push     (push),
    .pushData ({newChar[9], newChar[8], newChar[7:0]}),
    .pop      (pop),
    .headData (headData),
    .empty    (fifoEmpty),
    .full     (fifoFull)
  );

  assign ninthBit = headData[8] & ~fifoEmpty;

  // A discarded address-mode character cannot overrun
  always_ff @(posedge clock)
  begin
    if (rst || !serialPortOn || !continuousRxOn)
    begin
      overrun_q <= 1'b0;
    end
    else if (charDone && keepChar && fifoFull)
    begin
      overrun_q <= 1'b1;
    end
  end

  // Framing errors feed no interrupt path
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rxPendingFlag <= 1'b0;
      rxIrq         <= 1'b0;
    end
    else
    begin
      rxPendingFlag <= rxActive & ~(fifoEmpty & ~push) & ~(pop & ~push & headEmptyAfterPop());
      rxIrq         <= rxActive & ~fifoEmpty & ctrl_q[CTRL_RX_IRQ_ENABLE] &
                       ctrl_q[CTRL_PERIPH_IRQ_MASTER] &
                       ctrl_q[CTRL_GLOBAL_IRQ_ENABLE];
    end
  end

  function automatic logic headEmptyAfterPop();
    headEmptyAfterPop = !fifoFull;
  endfunction : headEmptyAfterPop

endmodule : asr_receiver

/* File: hdl/asr_rx_fifo.sv */
// Purpose : Receive FIFO of characters with their status bits
// Assumes : Caller never pushes when full or pops when empty
// Notes   : Flip-flop storage, index addressed
`timescale 1ns/1ps
module asr_rx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] pushData,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] headData,
  output logic                  empty,
  output logic                  full
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    rdIdx_q;
  logic [AW-1:0]    wrIdx_q;
  logic [AW:0]      count_q;

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_q[wrIdx_q] <= pushData;
    end
  end

  always_ff @(posedge clock)
  begin
    if (flush)
    begin
      rdIdx_q <= '0;
      wrIdx_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wrIdx_q <= (32'(wrIdx_q) == DEPTH - 1) ? '0 : wrIdx_q + 1'b1;
      end
      if (pop)
      begin
        rdIdx_q <= (32'(rdIdx_q) == DEPTH - 1) ? '0 : rdIdx_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  assign headData = mem_q[rdIdx_q];
  assign empty    = (count_q == '0);
  assign full     = (32'(count_q) == DEPTH);
endmodule : asr_rx_fifo

/* File: hdl/asr_tick_gen.sv */
// Purpose : Oversampling tick divider
// Assumes : Tick period is divisor+1 clocks
// Notes   : Held in reset while the receiver is off
`timescale 1ns/1ps
module asr_tick_gen #(
  parameter int DIV_W = 16
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  logic [DIV_W-1:0] count_q;

  always_ff @(posedge clock)
  begin
    if (rst || !run || count_q >= divisor)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_q + 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst || !run)
    begin
      tick <= 1'b0;
    end
    else
    begin
      tick <= (count_q >= divisor);
    end
  end
endmodule : asr_tick_gen

/* File: verif/asr_receiver_monitor.sv */
// Purpose : Port checker for the serial receiver
// Assumes : One clock domain, rst synchronous active high
// Notes   : Sees only top-level ports; bound below
`timescale 1ns/1ps
module asr_receiver_monitor (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        serialRxPin,
  input wire logic        rxPendingFlag,
  input wire logic        rxIrq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic mapped;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr < 8'h10);
  // ********
  // Bus timing
  // ********
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped not refused");
  a_mapped_ok: assert property (pready && mapped |-> !pslverr)
    else $error("mapped refused");
  a_err_rd_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  // ********
  // Receive flags
  // ********
  a_pend_fall: assert property ($fell(rxPendingFlag) |-> $past(pready) || $past(pready, 2))
    else $error("pending fell without access");
  a_irq_pend: assert property (rxIrq |-> rxPendingFlag || $past(rxPendingFlag))
    else $error("irq without pending");
  c_irq: cover property ($rose(rxIrq));
  c_refused: cover property (pready && pslverr);
  c_popped: cover property ($fell(rxPendingFlag));
endmodule : asr_receiver_monitor

bind asr_receiver asr_receiver_monitor u_asr_receiver_monitor (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .serialRxPin(serialRxPin), .rxPendingFlag(rxPendingFlag),
  .rxIrq(rxIrq)
);

/* File: verif/asr_receiver_tb_top.sv */
// Purpose : Self-checking bench for the serial receiver
// Assumes : Divisor 0, so sixteen clocks per bit
// Notes   : Read results are queued and checked by a watcher
`timescale 1ns/1ps
module asr_receiver_tb_top;
  import asr_pkg::*;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr;
  logic        rxLine, rxPendingFlag, rxIrq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [33:0] expQ[$];
  logic [33:0] e;
  logic [7:0]  b[4];
  int          fails, n_tests, seed;
  asr_receiver u_asr_receiver (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .serialRxPin(rxLine),
    .rxPendingFlag(rxPendingFlag), .rxIrq(rxIrq));
  asr_tx_model #(.BIT_CLKS(16)) u_asr_tx_model (.clock(clock), .line(rxLine));
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task results;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  task cmpBus(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmpBus
  task cmpFlags(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmpFlags
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [32:0] x);
    int i;
    expQ.push_back({w, x});
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 20)
    begin
      fails++;
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 33'h0);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0, {1'b0, x});
  endtask : rd
  // Flags are registered twice over, so allow two edges to settle
  task flags(input logic [1:0] x);
    repeat (2) @(posedge clock);
    #1 cmpFlags({rxPendingFlag, rxIrq}, x);
    @(posedge clock);
  endtask : flags
  always @(posedge clock)
    if (psel && penable && pready === 1'b1)
    begin
      e = expQ.pop_front();
      cmpBus({pslverr, e[33] ? 32'h0 : prdata}, e[32:0]);
    end
  initial
  begin
    seed = 240;
    fails = 0;
    n_tests = 0;
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(CTRL_OFS, {24'h0, CTRL_RESET});
    rd(BAUD_OFS, {16'h0, BAUD_DIV_RESET});
    apb(8'h10, 1'b0, 32'h0, {1'b1, 32'h0});
    wr(BAUD_OFS, 32'h0);
    wr(CTRL_OFS, 32'hE3);
    for (int i = 0; i < 4; i++) b[i] = 8'($random(seed));
    u_asr_tx_model.send({1'b0, b[0]}, 8, 1'b0);
    u_asr_tx_model.send({1'b0, b[1]}, 8, 1'b1);
    flags(2'b11);
    rd(STATUS_OFS, 32'h09);
    rd(DATA_OFS, {24'h0, b[0]});
    rd(STATUS_OFS, 32'h08);
    rd(DATA_OFS, {24'h0, b[1]});
    flags(2'b00);
    u_asr_tx_model.send({1'b0, b[2]}, 8, 1'b1);
    for (int m = 0; m < 8; m++)
    begin
      wr(CTRL_OFS, 32'h03 | (m << 5));
      flags({1'b1, m == 7});
    end
    rd(DATA_OFS, {24'h0, b[2]});
    u_asr_tx_model.glitch(4);
    flags(2'b00);
    // Synchronous mode selected: the line must be ignored
    wr(CTRL_OFS, 32'hF3);
    u_asr_tx_model.send({1'b0, b[0]}, 8, 1'b1);
    rd(STATUS_OFS, 32'h00);
    wr(CTRL_OFS, 32'hE3);
    // Status read in mid-character shows the receiver busy
    fork
      u_asr_tx_model.send({1'b0, b[3]}, 8, 1'b1);
      begin
        repeat (40) @(posedge clock);
        rd(STATUS_OFS, 32'h10);
      end
    join
    rd(DATA_OFS, {24'h0, b[3]});
    for (int i = 0; i < 3; i++) u_asr_tx_model.send({1'b0, b[i]}, 8, 1'b1);
    rd(STATUS_OFS, 32'h0A);
    rd(DATA_OFS, {24'h0, b[0]});
    rd(DATA_OFS, {24'h0, b[1]});
    rd(STATUS_OFS, 32'h02);
    u_asr_tx_model.send({1'b0, b[3]}, 8, 1'b1);
    flags(2'b00);
    wr(CTRL_OFS, 32'hE1);
    rd(STATUS_OFS, 32'h00);
    wr(CTRL_OFS, 32'hE7);
    u_asr_tx_model.send({1'b1, b[3]}, 9, 1'b1);
    rd(STATUS_OFS, 32'h0C);
    rd(DATA_OFS, {24'h0, b[3]});
    wr(CTRL_OFS, 32'hEF);
    u_asr_tx_model.send({1'b0, b[0]}, 9, 1'b1);
    flags(2'b00);
    u_asr_tx_model.send({1'b1, b[1]}, 9, 1'b1);
    rd(STATUS_OFS, 32'h0C);
    rd(DATA_OFS, {24'h0, b[1]});
    // Address mode cleared, nine-bit kept: a data character is stored
    wr(CTRL_OFS, 32'hE7);
    u_asr_tx_model.send({1'b0, b[2]}, 9, 1'b0);
    rd(STATUS_OFS, 32'h09);
    wr(CTRL_OFS, 32'hE1);
    rd(STATUS_OFS, 32'h01);
    flags(2'b00);
    wr(CTRL_OFS, 32'hE3);
    rd(STATUS_OFS, 32'h09);
    wr(CTRL_OFS, 32'hE2);
    rd(STATUS_OFS, 32'h00);
    flags(2'b00);
    // Second reset in mid-run must restore the register defaults
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(CTRL_OFS, {24'h0, CTRL_RESET});
    rd(BAUD_OFS, {16'h0, BAUD_DIV_RESET});
    results();
  end
endmodule : asr_receiver_tb_top

/* File: verif/asr_tx_model.sv */
// Purpose : Remote asynchronous transmitter on the receive line
// Assumes : BIT_CLKS clocks per bit, matching the receiver divisor
// Notes   : Line idles high; stop level selectable to force framing faults
`timescale 1ns/1ps
module asr_tx_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clock,
  output logic      line
);
  initial line = 1'b1;
  task send(input logic [8:0] d, input int nb, input logic stopLvl);
    line <= 1'b0;
    repeat (BIT_CLKS) @(posedge clock);
    for (int i = 0; i < nb; i++)
    begin
      line <= d[i];
      repeat (BIT_CLKS) @(posedge clock);
    end
    line <= stopLvl;
    repeat (BIT_CLKS) @(posedge clock);
    // Idle bit so a low stop still gives the next start its edge
    line <= 1'b1;
    repeat (BIT_CLKS) @(posedge clock);
  endtask : send
  task glitch(input int n);
    line <= 1'b0;
    repeat (n) @(posedge clock);
    line <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge clock);
  endtask : glitch
endmodule : asr_tx_model
